// File: src/ext_stack_pkg.sv
`default_nettype none
package ext_stack_pkg;
	// Widths of the data space, the program counter and the opcode word.
	localparam int ADDR_W = 12;
	localparam int PC_W = 21;
	localparam int WORD_W = 16;
	localparam int DATA_W = 8;
	localparam int OFS_W = 7;

	// Opcode patterns of the four extended instructions.
	localparam logic [15:0] OP_CALL_WORKING_REGISTER = 16'h0014;
	localparam logic [7:0] OP_MOVE_HI = 8'hEB;
	localparam logic [7:0] OP_PUSH_HI = 8'hFA;
	localparam logic [3:0] WORD2_PREFIX = 4'hF;
	localparam int MOVE_KIND_BIT = 7;

	// Return address step and frame pointer step.
	localparam logic [20:0] PC_STEP = 21'h000002;
	localparam logic [11:0] FP_STEP = 12'h001;

	// Indirect access registers: three groups of five addresses counting down.
	localparam logic [11:0] IND_BASE0 = 12'hFEF;
	localparam logic [11:0] IND_BASE1 = 12'hFE7;
	localparam logic [11:0] IND_BASE2 = 12'hFDF;
	localparam logic [11:0] IND_SPAN = 12'h005;
	localparam logic [7:0] READ_AS_ZERO = 8'h00;

	// Values after reset.
	localparam logic [11:0] ADDR_RST = 12'h000;
	localparam logic [20:0] PC_RST = 21'h000000;
	localparam logic [7:0] DATA_RST = 8'h00;

	typedef enum logic [1:0] {ST_IDLE, ST_CALL_NOP, ST_MOVE2} exec_state_t;

	// True when the address selects one of the indirect access registers.
	function automatic logic isIndirect(input logic [11:0] a);
		logic [11:0] d0;
		logic [11:0] d1;
		logic [11:0] d2;
		d0 = IND_BASE0 - a;
		d1 = IND_BASE1 - a;
		d2 = IND_BASE2 - a;
		return (a <= IND_BASE0 && d0 < IND_SPAN) || (a <= IND_BASE1 && d1 < IND_SPAN)
			|| (a <= IND_BASE2 && d2 < IND_SPAN);
	endfunction

	// Frame pointer plus a 7-bit offset, wrapping inside the 4096-byte space.
	function automatic logic [11:0] offsetAddr(input logic [11:0] fp, input logic [6:0] z);
		return fp + {5'h00, z};
	endfunction
endpackage
`default_nettype wire

// File: src/extended_stack_instr_exec.sv
// How it works
// [RULE_01] Indirect call pushes call address plus two.
// [RULE_02] Indirect call loads low PC from W.
// [RULE_03] High and upper PC come from latches.
// [RULE_04] Indirect call: one word, two cycles.
// [RULE_05] Call leaves W, flags, bank select untouched.
// [RULE_06] File move source is frame pointer plus offset.
// [RULE_07] File move destination is second-word 12-bit literal.
// [RULE_08] Move addresses span whole 4096-byte space.
// [RULE_09] Software never targets PC low or stack top.
// [RULE_10] Indirect register source reads as zero.
// [RULE_11] Indexed move: both addresses pointer plus offset.
// [RULE_12] Indirect destination of indexed move writes nothing.
// [RULE_13] Push writes literal at frame pointer address.
// [RULE_14] Push then decrements pointer, single cycle.
// [RULE_15] Moves: read first cycle, write after second.
// [RULE_16] No instruction touches arithmetic status flags.
`timescale 1ns/1ps
`default_nettype none

module extended_stack_instr_exec (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic nrst,
	// Fetched opcode word and the address it was fetched from.
	input wire logic opValid,
	input wire logic [15:0] opWord,
	input wire logic [20:0] pcIn,
	// Core registers read by the instructions.
	input wire logic [7:0] workReg,
	input wire logic [7:0] pcHighLatch,
	input wire logic [7:0] pcUpperLatch,
	input wire logic [11:0] framePtr,
	// Data memory read port; data answers in the cycle the enable is high.
	output logic memRdEn_r,
	output logic [11:0] memRdAddr_r,
	input wire logic [7:0] memRdData,
	// Data memory write port.
	output logic memWrEn_r,
	output logic [11:0] memWrAddr_r,
	output logic [7:0] memWrData_r,
	// Program counter load and return stack push.
	output logic pcLoad_r,
	output logic [20:0] pcTarget_r,
	output logic stackPush_r,
	output logic [20:0] stackData_r,
	// Frame pointer update.
	output logic fpLoad_r,
	output logic [11:0] fpValue_r,
	// Sequencing status towards the fetch logic.
	output logic busy_r,
	output logic wantWord2_r
);

	// Decoded view of the word that stands on the fetch port this cycle.
	logic isCall;
	logic isMove;
	logic isPush;
	logic word2Ok;
	logic [11:0] srcAddr;
	logic [11:0] dstIdx;
	logic [11:0] dstAddr;
	logic dstIndirect;
	logic [7:0] srcByte;
	logic [7:0] moveData;

	// Sequencer state and what the first move word leaves for the second.
	ext_stack_pkg::exec_state_t state_r;
	ext_stack_pkg::exec_state_t state_nxt;
	logic kindIdx_r;
	logic kindIdx_nxt;
	logic srcZero_r;
	logic srcZero_nxt;
	logic [7:0] rdHold_r;
	logic [7:0] rdHold_nxt;

	// Next values of the registered outputs.
	logic memRdEn_nxt;
	logic [11:0] memRdAddr_nxt;
	logic memWrEn_nxt;
	logic [11:0] memWrAddr_nxt;
	logic [7:0] memWrData_nxt;
	logic pcLoad_nxt;
	logic [20:0] pcTarget_nxt;
	logic stackPush_nxt;
	logic [20:0] stackData_nxt;
	logic fpLoad_nxt;
	logic [11:0] fpValue_nxt;
	logic busy_nxt;
	logic wantWord2_nxt;

	// Opcode decode and address arithmetic, shared by every state.
	always_comb begin
		isCall = (opWord == ext_stack_pkg::OP_CALL_WORKING_REGISTER);
		isMove = (opWord[15:8] == ext_stack_pkg::OP_MOVE_HI);
		isPush = (opWord[15:8] == ext_stack_pkg::OP_PUSH_HI);
		word2Ok = (opWord[15:12] == ext_stack_pkg::WORD2_PREFIX);
		// Offsets wrap inside the 12-bit space, so every byte is reachable.
		srcAddr = ext_stack_pkg::offsetAddr(framePtr, opWord[6:0]); // RULE_06 RULE_08
		// The second indexed word carries its offset in the same low seven bits.
		dstIdx = ext_stack_pkg::offsetAddr(framePtr, opWord[6:0]); // RULE_11
		dstAddr = kindIdx_r ? dstIdx : opWord[11:0]; // RULE_07
		dstIndirect = kindIdx_r && ext_stack_pkg::isIndirect(dstIdx); // RULE_12
		// The read port answers only while its enable stands.
		// A stalled second word therefore takes the copy held from that cycle.
		srcByte = memRdEn_r ? memRdData : rdHold_r;
		moveData = srcZero_r ? ext_stack_pkg::READ_AS_ZERO : srcByte; // RULE_10
	end

	// Next state and next outputs. Strobes default low, so each stands for one cycle.
	// The sequencer trusts the fetch logic to offer a move's second word next;
	// any other word offered then is taken as that second word.
	always_comb begin
		state_nxt = state_r;
		kindIdx_nxt = kindIdx_r;
		srcZero_nxt = srcZero_r;
		rdHold_nxt = srcByte;
		memRdEn_nxt = 1'h0;
		memRdAddr_nxt = memRdAddr_r;
		memWrEn_nxt = 1'h0;
		memWrAddr_nxt = memWrAddr_r;
		memWrData_nxt = memWrData_r;
		pcLoad_nxt = 1'h0;
		pcTarget_nxt = pcTarget_r;
		stackPush_nxt = 1'h0;
		stackData_nxt = stackData_r;
		fpLoad_nxt = 1'h0;
		fpValue_nxt = fpValue_r;
		busy_nxt = 1'h0;
		wantWord2_nxt = 1'h0;
		// Nothing here writes the working register, the flags or the bank select.
		unique case (state_r) // RULE_05 RULE_16
			ext_stack_pkg::ST_IDLE: begin
				if (opValid && isCall) begin
					// Return address push and the target load from W and the two latches, on the same edge.
					stackPush_nxt = 1'h1; // RULE_01
					stackData_nxt = pcIn + ext_stack_pkg::PC_STEP; // RULE_01
					pcLoad_nxt = 1'h1; // RULE_02
					pcTarget_nxt = {pcUpperLatch[4:0], pcHighLatch, workReg}; // RULE_02 RULE_03
					busy_nxt = 1'h1; // RULE_04
					state_nxt = ext_stack_pkg::ST_CALL_NOP; // RULE_04
				end else if (opValid && isMove) begin
					// The source read goes out now; its data is taken in the next cycle.
					memRdEn_nxt = 1'h1; // RULE_15
					memRdAddr_nxt = srcAddr; // RULE_06
					kindIdx_nxt = opWord[ext_stack_pkg::MOVE_KIND_BIT]; // RULE_11
					srcZero_nxt = ext_stack_pkg::isIndirect(srcAddr); // RULE_10
					busy_nxt = 1'h1;
					wantWord2_nxt = 1'h1;
					state_nxt = ext_stack_pkg::ST_MOVE2;
				end else if (opValid && isPush) begin
					// Store and pointer step land on the same edge.
					memWrEn_nxt = 1'h1; // RULE_13
					memWrAddr_nxt = framePtr; // RULE_13
					memWrData_nxt = opWord[7:0]; // RULE_13
					fpLoad_nxt = 1'h1; // RULE_14
					fpValue_nxt = framePtr - ext_stack_pkg::FP_STEP; // RULE_14
				end
			end
			ext_stack_pkg::ST_CALL_NOP: begin
				// Dead cycle while the new target is fetched; the word offered is dropped.
				state_nxt = ext_stack_pkg::ST_IDLE; // RULE_04
			end
			ext_stack_pkg::ST_MOVE2: begin
				if (!opValid) begin
					// Fetch stalled: keep asking for the second word.
					busy_nxt = 1'h1;
					wantWord2_nxt = 1'h1;
				end else begin
					state_nxt = ext_stack_pkg::ST_IDLE;
					// A malformed second word or an indirect destination writes nothing.
					if (word2Ok && !dstIndirect) begin // RULE_12
						memWrEn_nxt = 1'h1; // RULE_15
						memWrAddr_nxt = dstAddr; // RULE_07 RULE_11
						memWrData_nxt = moveData; // RULE_10
					end
				end
			end
			default: begin
				state_nxt = ext_stack_pkg::ST_IDLE;
			end
		endcase
	end

	// Registers only; every output leaves straight from a flip-flop.
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			state_r <= ext_stack_pkg::ST_IDLE;
			kindIdx_r <= 1'h0;
			srcZero_r <= 1'h0;
			rdHold_r <= ext_stack_pkg::DATA_RST;
			memRdEn_r <= 1'h0;
			memRdAddr_r <= ext_stack_pkg::ADDR_RST;
			memWrEn_r <= 1'h0;
			memWrAddr_r <= ext_stack_pkg::ADDR_RST;
			memWrData_r <= ext_stack_pkg::DATA_RST;
			pcLoad_r <= 1'h0;
			pcTarget_r <= ext_stack_pkg::PC_RST;
			stackPush_r <= 1'h0;
			stackData_r <= ext_stack_pkg::PC_RST;
			fpLoad_r <= 1'h0;
			fpValue_r <= ext_stack_pkg::ADDR_RST;
			busy_r <= 1'h0;
			wantWord2_r <= 1'h0;
		end else begin
			state_r <= state_nxt;
			kindIdx_r <= kindIdx_nxt;
			srcZero_r <= srcZero_nxt;
			rdHold_r <= rdHold_nxt;
			memRdEn_r <= memRdEn_nxt;
			memRdAddr_r <= memRdAddr_nxt;
			memWrEn_r <= memWrEn_nxt;
			memWrAddr_r <= memWrAddr_nxt;
			memWrData_r <= memWrData_nxt;
			pcLoad_r <= pcLoad_nxt;
			pcTarget_r <= pcTarget_nxt;
			stackPush_r <= stackPush_nxt;
			stackData_r <= stackData_nxt;
			fpLoad_r <= fpLoad_nxt;
			fpValue_r <= fpValue_nxt;
			busy_r <= busy_nxt;
			wantWord2_r <= wantWord2_nxt;
		end
	end

	// Checks run on the core clock and stay quiet while reset is low.
	default clocking chkClk @(posedge core_clk);
	endclocking
	default disable iff (!nrst);

	// An instruction word accepted while idle, one sequence per kind.
	sequence callSeen;
		state_r == ext_stack_pkg::ST_IDLE && opValid && opWord == ext_stack_pkg::OP_CALL_WORKING_REGISTER;
	endsequence

	sequence moveSeen;
		state_r == ext_stack_pkg::ST_IDLE && opValid && opWord[15:8] == ext_stack_pkg::OP_MOVE_HI;
	endsequence

	sequence pushSeen;
		state_r == ext_stack_pkg::ST_IDLE && opValid && opWord[15:8] == ext_stack_pkg::OP_PUSH_HI;
	endsequence

	// A first move word whose source lands on an indirect register.
	sequence srcIndSeen;
		state_r == ext_stack_pkg::ST_IDLE && opValid && opWord[15:8] == ext_stack_pkg::OP_MOVE_HI
			&& ext_stack_pkg::isIndirect(ext_stack_pkg::offsetAddr(framePtr, opWord[6:0]));
	endsequence

	// The second indexed word taken with an indirect destination.
	sequence badDestSeen;
		state_r == ext_stack_pkg::ST_MOVE2 && opValid && kindIdx_r
			&& ext_stack_pkg::isIndirect(ext_stack_pkg::offsetAddr(framePtr, opWord[6:0]));
	endsequence

	// The dead cycle after a call: busy, then no further load or push.
	sequence callTail;
		busy_r ##1 (!busy_r && !pcLoad_r && !stackPush_r);
	endsequence

	// The return address is the call's own address plus two.
	call_push_a: assert property (callSeen |=> stackPush_r // RULE_01
		&& stackData_r == $past(pcIn) + ext_stack_pkg::PC_STEP)
		else $error("call pushed a wrong return address");

	// The target is W below the two latch bytes.
	call_target_a: assert property (callSeen |=> pcLoad_r // RULE_03
		&& pcTarget_r == {$past(pcUpperLatch[4:0]), $past(pcHighLatch), $past(workReg)})
		else $error("call loaded a wrong target");

	// Two cycles in all, the second doing nothing.
	call_nop_a: assert property (callSeen |=> callTail) // RULE_04
		else $error("call did not idle in its second cycle");

	// Literal stored at the pointer, pointer stepped down on the same edge.
	push_store_a: assert property (pushSeen |=> memWrEn_r && fpLoad_r // RULE_14
		&& memWrAddr_r == $past(framePtr) && memWrData_r == $past(opWord[7:0])
		&& fpValue_r == $past(framePtr) - ext_stack_pkg::FP_STEP)
		else $error("push stored or stepped wrongly");

	// The first move cycle only reads; nothing is written before the second word.
	move_read_first_a: assert property (moveSeen |=> memRdEn_r && !memWrEn_r // RULE_15
		&& memRdAddr_r == ext_stack_pkg::offsetAddr($past(framePtr), $past(opWord[6:0])))
		else $error("move did not read its source first");

	// An indirect source reaches the write as zero.
	zero_source_a: assert property (srcIndSeen |=> ##1 (!memWrEn_r // RULE_10
		|| memWrData_r == ext_stack_pkg::READ_AS_ZERO))
		else $error("indirect source was not read as zero");

	// An indirect indexed destination leaves the move without its write; the source read still goes out.
	dest_nop_a: assert property (badDestSeen |=> !memWrEn_r) // RULE_12
		else $error("move wrote an indirect destination");

	// The file move writes the 12-bit literal of its second word.
	file_dest_a: assert property ((state_r == ext_stack_pkg::ST_MOVE2 && opValid // RULE_07
		&& !kindIdx_r && opWord[15:12] == ext_stack_pkg::WORD2_PREFIX)
		|=> memWrEn_r && memWrAddr_r == $past(opWord[11:0]))
		else $error("file move wrote a wrong destination");

	// The indexed move writes at the pointer plus its second offset.
	index_dest_a: assert property ((state_r == ext_stack_pkg::ST_MOVE2 && opValid // RULE_11
		&& kindIdx_r && opWord[15:12] == ext_stack_pkg::WORD2_PREFIX
		&& !ext_stack_pkg::isIndirect(ext_stack_pkg::offsetAddr(framePtr, opWord[6:0])))
		|=> memWrEn_r
		&& memWrAddr_r == ext_stack_pkg::offsetAddr($past(framePtr), $past(opWord[6:0])))
		else $error("indexed move wrote a wrong destination");
endmodule
`default_nettype wire

// File: tb/mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module mem_model (
	// Read port.
	input wire logic en,
	input wire logic [11:0] addr,
	output logic [7:0] data
);
	assign data = en ? addr[7:0] ^ 8'h5A : 8'hC3; // Address hash, junk when idle.
endmodule
`default_nettype wire

// File: tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	// Clock, reset, fetch port and core registers.
	logic core_clk = 1'h0;
	logic nrst = 1'h0;
	logic opValid = 1'h0;
	logic [15:0] opWord = 16'h0000;
	logic [20:0] pcIn = 21'h000100;
	logic [7:0] workReg = 8'h06;
	logic [7:0] pcHighLatch = 8'h10;
	logic [7:0] pcUpperLatch = 8'h00;
	logic [11:0] framePtr = 12'h080;
	// Design outputs and the memory answer.
	logic memRdEn;
	logic [11:0] memRdAddr;
	logic [7:0] memRdData;
	logic memWrEn;
	logic [11:0] memWrAddr;
	logic [7:0] memWrData;
	logic pcLoad;
	logic [20:0] pcTarget;
	logic stackPush;
	logic [20:0] stackData;
	logic fpLoad;
	logic [11:0] fpValue;
	logic busy;
	logic wantWord2;
	int err_total = 0;
	int tests_run = 0;

	// A 200 MHz clock.
	always #2.5 core_clk = ~core_clk;

	extended_stack_instr_exec dut (
		.core_clk(core_clk),
		.nrst(nrst),
		.opValid(opValid),
		.opWord(opWord),
		.pcIn(pcIn),
		.workReg(workReg),
		.pcHighLatch(pcHighLatch),
		.pcUpperLatch(pcUpperLatch),
		.framePtr(framePtr),
		.memRdEn_r(memRdEn),
		.memRdAddr_r(memRdAddr),
		.memRdData(memRdData),
		.memWrEn_r(memWrEn),
		.memWrAddr_r(memWrAddr),
		.memWrData_r(memWrData),
		.pcLoad_r(pcLoad),
		.pcTarget_r(pcTarget),
		.stackPush_r(stackPush),
		.stackData_r(stackData),
		.fpLoad_r(fpLoad),
		.fpValue_r(fpValue),
		.busy_r(busy),
		.wantWord2_r(wantWord2)
	);

	// Data memory: each byte reads as its address hashed with 5Ah.
	mem_model mem (.en(memRdEn), .addr(memRdAddr), .data(memRdData));

	// The one compare; every result is widened to the widest field.
	task automatic check(input logic [20:0] got, input logic [20:0] want, input string what);
		tests_run++;
		if (got !== want) begin
			err_total++;
			$display("ERROR %0t %s: got %0h want %0h", $time, what, got, want);
		end
	endtask

	// Puts one word on the fetch port and moves to just after the edge that takes it.
	task automatic feed(input logic valid, input logic [15:0] word);
		opValid = valid;
		opWord = word;
		@(posedge core_clk);
		#1;
	endtask

	// One two-word move, judged at its read and at its write.
	task automatic moveCheck(input logic [11:0] fp, input logic [15:0] w1, input logic [15:0] w2,
		input logic [11:0] rdAddr, input logic wrOn, input logic [11:0] wrAddr,
		input logic [7:0] wrData);
		framePtr = fp;
		feed(1'h1, w1);
		check(21'(memRdEn), 21'h000001, "source read");
		check(21'(memRdAddr), 21'(rdAddr), "source address");
		check(21'(memWrEn), 21'h000000, "no write in first cycle");
		check(21'(wantWord2), 21'h000001, "second word wanted");
		feed(1'h1, w2);
		check(21'(memWrEn), 21'(wrOn), "destination write");
		if (wrOn) begin
			check(21'(memWrAddr), 21'(wrAddr), "destination address");
			check(21'(memWrData), 21'(wrData), "moved byte");
		end
		check(21'(busy), 21'h000000, "move done in two cycles");
		feed(1'h0, 16'h0000);
		check(21'(memWrEn), 21'h000000, "write strobe one cycle");
	endtask

	// Literal push at 080h; the pointer steps to 07Fh.
	task automatic pushScenario;
		framePtr = 12'h080;
		feed(1'h1, 16'hFA08);
		check(21'(memWrEn), 21'h000001, "push write");
		check(21'(memWrAddr), 21'h000080, "push address");
		check(21'(memWrData), 21'h000008, "push data");
		check(21'(fpLoad), 21'h000001, "pointer load");
		check(21'(fpValue), 21'h00007F, "pointer value");
		check(21'(busy), 21'h000000, "push single cycle");
		feed(1'h0, 16'h0000);
		check(21'(memWrEn), 21'h000000, "push strobe one cycle");
	endtask

	// Destinations here never hit the PC low byte or the stack top bytes.
	task automatic fileMoveScenario;
		moveCheck(12'h080, 16'hEB05, 16'hF123, 12'h085, 1'h1, 12'h123, 8'hDF);
		moveCheck(12'hFF0, 16'hEB7F, 16'hF000, 12'h06F, 1'h1, 12'h000, 8'h35);
	endtask

	// Indexed to indexed, plain and with an indirect destination.
	task automatic indexMoveScenario;
		moveCheck(12'h080, 16'hEB85, 16'hF006, 12'h085, 1'h1, 12'h086, 8'hDF);
		moveCheck(12'hFE0, 16'hEB81, 16'hF00F, 12'hFE1, 1'h0, 12'h000, 8'h00);
	endtask

	// A source on an indirect register moves zero, not what memory shows.
	task automatic zeroSourceScenario;
		moveCheck(12'hFE0, 16'hEB0B, 16'hF124, 12'hFEB, 1'h1, 12'h124, 8'h00);
	endtask

	// The second word arrives a cycle late; the source byte must be held.
	task automatic stallScenario;
		framePtr = 12'h080;
		feed(1'h1, 16'hEB05);
		feed(1'h0, 16'h0000);
		check(21'(wantWord2), 21'h000001, "still wanting word two");
		check(21'(memWrEn), 21'h000000, "no write while stalled");
		feed(1'h1, 16'hF124);
		check(21'(memWrEn), 21'h000001, "late write");
		check(21'(memWrAddr), 21'h000124, "late address");
		check(21'(memWrData), 21'h0000DF, "held byte");
		feed(1'h0, 16'h0000);
	endtask

	// Indirect call at 0100h with W 06h and latches 10h and 00h.
	task automatic callScenario;
		feed(1'h1, 16'h0014);
		check(21'(stackPush), 21'h000001, "return push");
		check(stackData, 21'h000102, "return address");
		check(21'(pcLoad), 21'h000001, "pc load");
		check(pcTarget, 21'h001006, "call target");
		check(21'(busy), 21'h000001, "busy in call");
		feed(1'h0, 16'h0000);
		check(21'(busy), 21'h000000, "call done in two cycles");
		check(21'(pcLoad), 21'h000000, "no second load");
		check(21'(stackPush), 21'h000000, "no second push");
	endtask

	// Reset in the middle of a move clears it; a push then runs normally.
	task automatic resetScenario;
		framePtr = 12'h080;
		feed(1'h1, 16'hEB05);
		nrst = 1'h0;
		opValid = 1'h0;
		@(posedge core_clk);
		#1;
		check(21'(memRdEn), 21'h000000, "read cleared by reset");
		check(21'(busy), 21'h000000, "busy cleared by reset");
		nrst = 1'h1;
		feed(1'h0, 16'h0000);
		check(21'(memWrEn), 21'h000000, "no write after reset");
		feed(1'h1, 16'hFA08);
		check(21'(memWrEn), 21'h000001, "push after reset");
		feed(1'h0, 16'h0000);
	endtask

	// Counts, verdict and the end of the run.
	task automatic results;
		$display("checks %0d errors %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// Reset for ten cycles, released just after a rising edge.
	initial begin
		repeat (10) @(posedge core_clk);
		#1;
		nrst = 1'h1;
		pushScenario();
		fileMoveScenario();
		indexMoveScenario();
		zeroSourceScenario();
		stallScenario();
		callScenario();
		resetScenario();
		results();
	end
endmodule
`default_nettype wire
